// >>> src/ipr_defs.svh
// Register offsets, indexes, field positions and reset values of the remap
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define IPR_IDX_UART2      4'h0
`define IPR_IDX_SPI1_CD    4'h1
`define IPR_IDX_SPI1_SEL   4'h2
`define IPR_IDX_SPI2_CD    4'h3
`define IPR_IDX_SPI2_SEL   4'h4
`define IPR_IDX_CAN        4'h5
`define IPR_IDX_SPI3_CD    4'h6
`define IPR_IDX_SPI3_SEL   4'h7
`define IPR_IDX_SYNC1      4'h8
`define IPR_IDX_SYNC2      4'h9
`define IPR_IDX_FLT56      4'hA
`define IPR_IDX_FLT78      4'hB
`define IPR_NREG           4'hC

// ----------------------------------------------------------------------
// Byte offsets on the bus
// ----------------------------------------------------------------------
`define IPR_OFF_UART2      12'h000
`define IPR_OFF_SPI1_CD    12'h004
`define IPR_OFF_SPI1_SEL   12'h008
`define IPR_OFF_SPI2_CD    12'h00C
`define IPR_OFF_SPI2_SEL   12'h010
`define IPR_OFF_CAN        12'h014
`define IPR_OFF_SPI3_CD    12'h018
`define IPR_OFF_SPI3_SEL   12'h01C
`define IPR_OFF_SYNC1      12'h020
`define IPR_OFF_SYNC2      12'h024
`define IPR_OFF_FLT56      12'h028
`define IPR_OFF_FLT78      12'h02C

// ----------------------------------------------------------------------
// Byte masks of implemented fields, reset value, field positions
// ----------------------------------------------------------------------
`define IPR_MASK_LO        16'h00FF
`define IPR_MASK_HI        16'hFF00
`define IPR_MASK_BOTH      16'hFFFF
`define IPR_RST_VAL        16'h0000
`define IPR_HI_LSB         8
`define IPR_LO_LSB         0
`define IPR_ZERO_HALF      16'h0000

`endif

// >>> src/ipr_pkg.sv
// Types and register decoding helpers of the input remap block
`include "ipr_defs.svh"

package ipr_pkg;

  typedef logic [7:0]  ipr_idx_t;   // Pin selector value
  typedef logic [15:0] ipr_word_t;  // Selector register word
  typedef logic [3:0]  ipr_reg_t;   // Register index

  // Peripheral inputs served by the remap
  typedef enum int {
    F_UART2_RX, F_SPI1_CLK, F_SPI1_DAT, F_SPI1_SEL,
    F_SPI2_CLK, F_SPI2_DAT, F_SPI2_SEL, F_CAN2_RX, F_CAN1_RX,
    F_SPI3_CLK, F_SPI3_DAT, F_SPI3_SEL, F_SYNC_A, F_SYNC_B,
    F_FAULT_F, F_FAULT_E, F_FAULT_H, F_FAULT_G, F_COUNT
  } ipr_field_t;

  // Writable bits of each register; the rest read as zero
  function automatic ipr_word_t ipr_reg_mask(input ipr_reg_t r);
    case (r)
      `IPR_IDX_UART2,
      `IPR_IDX_SPI1_SEL,
      `IPR_IDX_SPI2_SEL,
      `IPR_IDX_SPI3_SEL,
      `IPR_IDX_SYNC2:    ipr_reg_mask = `IPR_MASK_LO;
      `IPR_IDX_SYNC1:    ipr_reg_mask = `IPR_MASK_HI;
      `IPR_IDX_SPI1_CD,
      `IPR_IDX_SPI2_CD,
      `IPR_IDX_CAN,
      `IPR_IDX_SPI3_CD,
      `IPR_IDX_FLT56,
      `IPR_IDX_FLT78:    ipr_reg_mask = `IPR_MASK_BOTH;
      default:           ipr_reg_mask = `IPR_ZERO_HALF;
    endcase
  endfunction : ipr_reg_mask

endpackage : ipr_pkg

// >>> src/ipr_reg_if.sv
// Register access carrier between the bus slave and the selector file
`timescale 1ns/10ps
`default_nettype none

interface ipr_reg_if;
  import ipr_pkg::*;

  logic      wr_en;  // One-cycle write strobe, mapped address only
  ipr_reg_t  idx;    // Register index of the access
  ipr_word_t wdata;  // Write data, low half of the bus word
  ipr_word_t rdata;  // Read word of the indexed register

  modport bus  (output wr_en, output idx, output wdata, input rdata);
  modport regs (input wr_en, input idx, input wdata, output rdata);
endinterface : ipr_reg_if

`default_nettype wire

// >>> src/ipr_apb_slave.sv
// APB slave: address decode, write strobe and read answer
`timescale 1ns/10ps
`default_nettype none

module ipr_apb_slave #(
  parameter int ADDR_W = 12
) (
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  ipr_reg_if.bus                 rif
);
  import ipr_pkg::*;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  wire logic              access;   // Access phase of a transfer
  wire logic              aligned;  // Word aligned address
  wire logic [ADDR_W-3:0] word;     // Word index of the address
  wire logic              hit;      // Address names a register

  assign access  = psel & penable;
  assign aligned = (paddr[1:0] == 2'h0);
  assign word    = paddr[ADDR_W-1:2];
  assign hit     = aligned & (word < (ADDR_W-2)'(`IPR_NREG));

  // --------------------------------------------------------------------
  // Strobes and answer; zero wait states
  // --------------------------------------------------------------------
  assign rif.wr_en = access & pwrite & hit;
  assign rif.idx   = word[3:0];
  assign rif.wdata = pwdata[15:0];
  assign pready    = 1'b1;
  // Unmapped or misaligned: error, write dropped, read zero
  assign pslverr   = access & ~hit;
  assign prdata    = (access & ~pwrite & hit) ?
                     {`IPR_ZERO_HALF, rif.rdata} : 32'h00000000;
endmodule : ipr_apb_slave

`default_nettype wire

// >>> src/ipr_pin_select.sv
// One selector: picks the level of the pin named by an index value
`timescale 1ns/10ps
`default_nettype none

module ipr_pin_select #(
  parameter int NPINS    = 64,
  parameter int PIN_BASE = 1
) (
  input  wire logic [7:0]       sel,
  input  wire logic [NPINS-1:0] pins,
  output logic                  level
);
  // Table: selector value PIN_BASE+k reaches pin k; others give low
  always_comb begin
    level = 1'b0;
    for (int k = 0; k < NPINS; k++) begin
      if (int'(sel) == PIN_BASE + k) begin
        level = pins[k]; // [RULE19]
      end
    end
  end
endmodule : ipr_pin_select

`default_nettype wire

// >>> src/ipr_top.sv
// Input remap: selector registers on APB steering pins to peripherals
//
// How it works
// RULE1: UART2 receive from low byte selector
// RULE2: SPI1 clock from first register high byte
// RULE3: SPI1 data from first register low byte
// RULE4: SPI1 select from low byte, upper unused
// RULE5: SPI2 clock from first register high byte
// RULE6: SPI2 data from first register low byte
// RULE7: SPI2 select from low byte, upper unused
// RULE8: CAN2 receive from shared register high byte
// RULE9: CAN1 receive from shared register low byte
// RULE10: SPI3 clock from first register high byte
// RULE11: SPI3 data from first register low byte
// RULE12: SPI3 select from low byte, upper unused
// RULE13: Sync input one from high byte only
// RULE14: Sync input two from low byte only
// RULE15: Faults six high, five low, shared register
// RULE16: Faults eight high, seven low, shared register
// RULE17: Unused bytes read zero, ignore writes
// RULE18: Fields reset to zero, always read/write
// RULE19: Index picks pin through parameterised table
`timescale 1ns/10ps
`default_nettype none

module ipr_top #(
  parameter int ADDR_W   = 12, // APB address width
  parameter int NPINS    = 64, // Number of remappable pins
  parameter int PIN_BASE = 1   // Selector value of remappable pin 0
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NPINS-1:0]  remappable_pin,
  output logic                   uart2_receive_input,
  output logic                   spi1_clock_input,
  output logic                   spi1_data_input,
  output logic                   spi1_select_input,
  output logic                   spi2_clock_input,
  output logic                   spi2_data_input,
  output logic                   spi2_select_input,
  output logic                   can2_receive_input,
  output logic                   can1_receive_input,
  output logic                   spi3_clock_input,
  output logic                   spi3_data_input,
  output logic                   spi3_select_input,
  output logic                   pwm_sync_a_input,
  output logic                   pwm_sync_b_input,
  output logic                   pwm_fault_e_input,
  output logic                   pwm_fault_f_input,
  output logic                   pwm_fault_g_input,
  output logic                   pwm_fault_h_input
);
  import ipr_pkg::*;

  localparam int NREG   = int'(`IPR_NREG);
  localparam int NFIELD = int'(F_COUNT);

  // --------------------------------------------------------------------
  // Field placement: register and byte of each peripheral input
  // --------------------------------------------------------------------
  function automatic ipr_reg_t field_reg(input int f);
    case (f)
      F_UART2_RX: field_reg = `IPR_IDX_UART2;    // [RULE1]
      F_SPI1_CLK,
      F_SPI1_DAT: field_reg = `IPR_IDX_SPI1_CD;  // [RULE2] [RULE3]
      F_SPI1_SEL: field_reg = `IPR_IDX_SPI1_SEL; // [RULE4]
      F_SPI2_CLK,
      F_SPI2_DAT: field_reg = `IPR_IDX_SPI2_CD;  // [RULE5] [RULE6]
      F_SPI2_SEL: field_reg = `IPR_IDX_SPI2_SEL; // [RULE7]
      F_CAN2_RX,
      F_CAN1_RX:  field_reg = `IPR_IDX_CAN;      // [RULE8] [RULE9]
      F_SPI3_CLK,
      F_SPI3_DAT: field_reg = `IPR_IDX_SPI3_CD;  // [RULE10] [RULE11]
      F_SPI3_SEL: field_reg = `IPR_IDX_SPI3_SEL; // [RULE12]
      F_SYNC_A:   field_reg = `IPR_IDX_SYNC1;    // [RULE13]
      F_SYNC_B:   field_reg = `IPR_IDX_SYNC2;    // [RULE14]
      F_FAULT_F,
      F_FAULT_E:  field_reg = `IPR_IDX_FLT56;    // [RULE15]
      F_FAULT_H,
      F_FAULT_G:  field_reg = `IPR_IDX_FLT78;    // [RULE16]
      default:    field_reg = `IPR_IDX_UART2;
    endcase
  endfunction : field_reg

  // High byte users; all others sit in bits 7-0
  function automatic bit field_hi(input int f);
    case (f)
      F_SPI1_CLK, F_SPI2_CLK, F_CAN2_RX, F_SPI3_CLK,
      F_SYNC_A, F_FAULT_F, F_FAULT_H: field_hi = 1'b1; // [RULE13]
      default:                        field_hi = 1'b0;
    endcase
  endfunction : field_hi

  // Reference lookup, same table as the selectors, for checking only
  function automatic logic pin_at(input logic [7:0] v,
                                  input logic [NPINS-1:0] p);
    int k;
    k = int'(v) - PIN_BASE;
    pin_at = 1'b0;
    if (k >= 0 && k < NPINS) begin
      pin_at = p[k];
    end
  endfunction : pin_at

  // --------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------
  ipr_reg_if rif ();  // Register access carrier

  ipr_apb_slave #(
    .ADDR_W (ADDR_W)
  ) u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rif     (rif)
  );

  // --------------------------------------------------------------------
  // Selector registers
  // --------------------------------------------------------------------
  ipr_word_t reg_q [NREG];   // Selector words, unused bytes kept zero
  ipr_word_t wr_word;        // Write data with unused bytes cleared
  wire logic idx_ok;         // Read index inside the file

  assign wr_word = rif.wdata & ipr_reg_mask(rif.idx); // [RULE17]
  assign idx_ok  = (rif.idx < `IPR_NREG);
  assign rif.rdata = idx_ok ? reg_q[rif.idx] : `IPR_ZERO_HALF;

  // Reset clears all fields; a write replaces the implemented bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int r = 0; r < NREG; r++) begin
        reg_q[r] <= `IPR_RST_VAL; // [RULE18]
      end
    end else if (rif.wr_en) begin
      reg_q[rif.idx] <= wr_word; // [RULE18]
    end
  end

  // --------------------------------------------------------------------
  // Pin selection, one selector per peripheral input
  // --------------------------------------------------------------------
  ipr_idx_t         sel_idx [NFIELD]; // Selector value of each field
  logic [NFIELD-1:0] sel_lvl;         // Selected pin level
  logic [NFIELD-1:0] periph_q;        // Registered peripheral inputs

  for (genvar f = 0; f < NFIELD; f++) begin : g_field
    localparam ipr_reg_t R  = field_reg(f);
    localparam bit       HI = field_hi(f);

    // Byte of the owning register that holds this index
    assign sel_idx[f] = HI ? reg_q[R][`IPR_HI_LSB +: 8]
                           : reg_q[R][`IPR_LO_LSB +: 8];

    ipr_pin_select #(
      .NPINS    (NPINS),
      .PIN_BASE (PIN_BASE)
    ) u_sel (
      .sel   (sel_idx[f]),
      .pins  (remappable_pin),
      .level (sel_lvl[f])
    );

    // Each output follows the pin its field names
    a_field_route: assert property ( // [RULE19]
      @(posedge clk) disable iff (!nrst)
      1'b1 |=> periph_q[f] == pin_at($past(sel_idx[f]),
                                     $past(remappable_pin)))
      else $error("peripheral input does not follow selected pin");
  end

  // Levels reach the peripherals one clock after the pins; one process
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periph_q <= '0;
    end else begin
      periph_q <= sel_lvl; // [RULE19]
    end
  end

  // --------------------------------------------------------------------
  // Peripheral input outputs
  // --------------------------------------------------------------------
  assign uart2_receive_input = periph_q[F_UART2_RX];
  assign spi1_clock_input    = periph_q[F_SPI1_CLK];
  assign spi1_data_input     = periph_q[F_SPI1_DAT];
  assign spi1_select_input   = periph_q[F_SPI1_SEL];
  assign spi2_clock_input    = periph_q[F_SPI2_CLK];
  assign spi2_data_input     = periph_q[F_SPI2_DAT];
  assign spi2_select_input   = periph_q[F_SPI2_SEL];
  assign can2_receive_input  = periph_q[F_CAN2_RX];
  assign can1_receive_input  = periph_q[F_CAN1_RX];
  assign spi3_clock_input    = periph_q[F_SPI3_CLK];
  assign spi3_data_input     = periph_q[F_SPI3_DAT];
  assign spi3_select_input   = periph_q[F_SPI3_SEL];
  assign pwm_sync_a_input    = periph_q[F_SYNC_A];
  assign pwm_sync_b_input    = periph_q[F_SYNC_B];
  assign pwm_fault_e_input   = periph_q[F_FAULT_E];
  assign pwm_fault_f_input   = periph_q[F_FAULT_F];
  assign pwm_fault_g_input   = periph_q[F_FAULT_G];
  assign pwm_fault_h_input   = periph_q[F_FAULT_H];

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ipr_word_t uart_w;  // Helper copies of selector words
  ipr_word_t spi1_w;
  ipr_word_t can_w;
  ipr_word_t sync1_w;
  ipr_word_t flt78_w;
  ipr_word_t spi1s_w;
  ipr_word_t spi2_w;
  ipr_word_t spi2s_w;
  ipr_word_t spi3_w;
  ipr_word_t spi3s_w;
  ipr_word_t sync2_w;
  ipr_word_t flt56_w;
  wire logic rd_hit;  // Read access to a mapped register

  assign uart_w  = reg_q[`IPR_IDX_UART2];
  assign spi1_w  = reg_q[`IPR_IDX_SPI1_CD];
  assign can_w   = reg_q[`IPR_IDX_CAN];
  assign sync1_w = reg_q[`IPR_IDX_SYNC1];
  assign flt78_w = reg_q[`IPR_IDX_FLT78];
  assign spi1s_w = reg_q[`IPR_IDX_SPI1_SEL];
  assign spi2_w  = reg_q[`IPR_IDX_SPI2_CD];
  assign spi2s_w = reg_q[`IPR_IDX_SPI2_SEL];
  assign spi3_w  = reg_q[`IPR_IDX_SPI3_CD];
  assign spi3s_w = reg_q[`IPR_IDX_SPI3_SEL];
  assign sync2_w = reg_q[`IPR_IDX_SYNC2];
  assign flt56_w = reg_q[`IPR_IDX_FLT56];
  assign rd_hit  = psel & penable & ~pwrite & ~pslverr;

  a_uart_route: assert property ( // [RULE1]
    1'b1 |=> uart2_receive_input ==
             pin_at($past(uart_w[7:0]), $past(remappable_pin)))
    else $error("uart2 receive not taken from bits 7-0");

  a_spi1_clock_route: assert property ( // [RULE2]
    1'b1 |=> spi1_clock_input ==
             pin_at($past(spi1_w[15:8]), $past(remappable_pin)))
    else $error("spi1 clock not taken from bits 15-8");

  a_can2_route: assert property ( // [RULE8]
    1'b1 |=> can2_receive_input ==
             pin_at($past(can_w[15:8]), $past(remappable_pin)))
    else $error("can2 receive not taken from bits 15-8");

  a_sync_a_route: assert property ( // [RULE13]
    1'b1 |=> pwm_sync_a_input ==
             pin_at($past(sync1_w[15:8]), $past(remappable_pin)))
    else $error("sync input one not taken from bits 15-8");

  a_fault_h_route: assert property ( // [RULE16]
    1'b1 |=> pwm_fault_h_input ==
             pin_at($past(flt78_w[15:8]), $past(remappable_pin)))
    else $error("fault h not taken from bits 15-8");

  a_spi1_data_route: assert property ( // [RULE3]
    1'b1 |=> spi1_data_input ==
             pin_at($past(spi1_w[7:0]), $past(remappable_pin)))
    else $error("spi1 data not taken from bits 7-0");

  a_spi1_select_route: assert property ( // [RULE4]
    1'b1 |=> spi1_select_input ==
             pin_at($past(spi1s_w[7:0]), $past(remappable_pin)))
    else $error("spi1 select not taken from bits 7-0");

  a_spi2_clock_route: assert property ( // [RULE5]
    1'b1 |=> spi2_clock_input ==
             pin_at($past(spi2_w[15:8]), $past(remappable_pin)))
    else $error("spi2 clock not taken from bits 15-8");

  a_spi2_data_route: assert property ( // [RULE6]
    1'b1 |=> spi2_data_input ==
             pin_at($past(spi2_w[7:0]), $past(remappable_pin)))
    else $error("spi2 data not taken from bits 7-0");

  a_spi2_select_route: assert property ( // [RULE7]
    1'b1 |=> spi2_select_input ==
             pin_at($past(spi2s_w[7:0]), $past(remappable_pin)))
    else $error("spi2 select not taken from bits 7-0");

  a_can1_route: assert property ( // [RULE9]
    1'b1 |=> can1_receive_input ==
             pin_at($past(can_w[7:0]), $past(remappable_pin)))
    else $error("can1 receive not taken from bits 7-0");

  a_spi3_clock_route: assert property ( // [RULE10]
    1'b1 |=> spi3_clock_input ==
             pin_at($past(spi3_w[15:8]), $past(remappable_pin)))
    else $error("spi3 clock not taken from bits 15-8");

  a_spi3_data_route: assert property ( // [RULE11]
    1'b1 |=> spi3_data_input ==
             pin_at($past(spi3_w[7:0]), $past(remappable_pin)))
    else $error("spi3 data not taken from bits 7-0");

  a_spi3_select_route: assert property ( // [RULE12]
    1'b1 |=> spi3_select_input ==
             pin_at($past(spi3s_w[7:0]), $past(remappable_pin)))
    else $error("spi3 select not taken from bits 7-0");

  a_sync_b_route: assert property ( // [RULE14]
    1'b1 |=> pwm_sync_b_input ==
             pin_at($past(sync2_w[7:0]), $past(remappable_pin)))
    else $error("sync input two not taken from bits 7-0");

  a_fault_e_route: assert property ( // [RULE15]
    1'b1 |=> pwm_fault_e_input ==
             pin_at($past(flt56_w[7:0]), $past(remappable_pin)))
    else $error("fault e not taken from bits 7-0");

  a_unimpl_read_zero: assert property ( // [RULE17]
    rd_hit |-> prdata[31:16] == `IPR_ZERO_HALF &&
               (prdata[15:0] & ~ipr_reg_mask(rif.idx)) == `IPR_ZERO_HALF)
    else $error("unimplemented bits read nonzero");

  a_write_lands: assert property ( // [RULE18]
    rif.wr_en |=> reg_q[$past(rif.idx)] == $past(wr_word))
    else $error("written selector did not take the value");

  a_hold_no_write: assert property ( // [RULE18]
    !(rif.wr_en && rif.idx == `IPR_IDX_CAN) |=> $stable(can_w))
    else $error("selector changed without a write");

  a_misaligned_err: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr && pready)
    else $error("misaligned access not refused");

  c_uart_write: cover property (
    rif.wr_en && rif.idx == `IPR_IDX_UART2 ##[1:8]
    $rose(uart2_receive_input));
  c_fault_read: cover property (rd_hit && rif.idx == `IPR_IDX_FLT56);
  c_unmapped: cover property (pslverr && pwrite);
endmodule : ipr_top

`default_nettype wire

// >>> dv/ipr_far_model.sv
// Peripheral side model: captures the remapped inputs on each clock
`timescale 1ns/10ps
`default_nettype none

module ipr_far_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [17:0] levels,
  output var  logic [17:0] seen_q
);
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Peripherals sample their remapped inputs on the system clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_q <= 18'h00000;  // Nothing captured during reset
    end else begin
      seen_q <= levels;     // Level seen by each peripheral
    end
  end
endmodule : ipr_far_model

`default_nettype wire

// >>> dv/input_pin_remap_test.sv
// Self-checking bench of the input remap block
`timescale 1ns/10ps
`default_nettype none
`include "ipr_defs.svh"

module input_pin_remap_test;
  import ipr_pkg::*;

  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  localparam int PIN_BASE = 1;  // Selector value of pin 0
  logic        clk;              // System clock
  logic        nrst;             // Reset, active low
  logic        psel;             // Bus select
  logic        penable;          // Bus access phase
  logic        pwrite;           // Bus direction
  logic [11:0] paddr;            // Bus address
  logic [31:0] pwdata;           // Bus write data
  logic [31:0] prdata;           // Bus read data
  logic        pready;           // Bus ready
  logic        pslverr;          // Bus error
  logic [63:0] pins;             // Remappable pin levels
  logic [17:0] outs;             // Peripheral inputs
  logic [17:0] seen;             // Levels captured by the peripherals
  int          errors;           // Mismatch count
  int          samples_checked;  // Comparison count
  logic [31:0] rd;               // Last read word
  logic        err;              // Last error flag
  logic [11:0] offs [12] = '{12'h000, 12'h004, 12'h008, 12'h00C,
    12'h010, 12'h014, 12'h018, 12'h01C, 12'h020, 12'h024, 12'h028,
    12'h02C};                    // Register byte offsets
  logic [15:0] masks [12] = '{16'h00FF, 16'hFFFF, 16'h00FF, 16'hFFFF,
    16'h00FF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'hFF00, 16'h00FF,
    16'hFFFF, 16'hFFFF};         // Implemented bits of each register
  int          freg [18] = '{0, 1, 1, 2, 3, 3, 4, 5, 5, 6, 6, 7, 8, 9,
    10, 10, 11, 11};             // Register holding each field
  int          flsb [18] = '{0, 8, 0, 0, 8, 0, 0, 8, 0, 8, 0, 0, 8, 0,
    8, 0, 8, 0};                 // Field position in its register

  // ----------------------------------------------------------------
  // Design, peripheral model, clock and watchdog
  // ----------------------------------------------------------------
  ipr_top #(.ADDR_W(12), .NPINS(64), .PIN_BASE(PIN_BASE)) dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .remappable_pin(pins),
    .uart2_receive_input(outs[0]), .spi1_clock_input(outs[1]),
    .spi1_data_input(outs[2]), .spi1_select_input(outs[3]),
    .spi2_clock_input(outs[4]), .spi2_data_input(outs[5]),
    .spi2_select_input(outs[6]), .can2_receive_input(outs[7]),
    .can1_receive_input(outs[8]), .spi3_clock_input(outs[9]),
    .spi3_data_input(outs[10]), .spi3_select_input(outs[11]),
    .pwm_sync_a_input(outs[12]), .pwm_sync_b_input(outs[13]),
    .pwm_fault_f_input(outs[14]), .pwm_fault_e_input(outs[15]),
    .pwm_fault_h_input(outs[16]), .pwm_fault_g_input(outs[17]));

  ipr_far_model far (.clk(clk), .nrst(nrst), .levels(outs),
    .seen_q(seen));

  // Free running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Counts a comparison and reports a mismatch
  task automatic chk(input string what, input logic [31:0] s,
                     input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  // One bus transfer: setup, access until ready, then release
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Drives the pins at an edge, then waits four clocks for the outputs to settle
  task automatic pin_wait(input logic [63:0] v);
    @(posedge clk);
    pins <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask : pin_wait

  // Prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pins = 64'h0;
    errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // Reset values and byte masks of every selector register
    for (int r = 0; r < 12; r++) begin
      apb(1'b0, offs[r], 32'h0);
      chk("reset value", rd, 32'h0);
      apb(1'b1, offs[r], 32'hFFFFFFFF);
      apb(1'b0, offs[r], 32'h0);
      chk("masked value", rd, {16'h0, masks[r]});
      chk("error flag", {31'h0, err}, 32'h0);
      apb(1'b1, offs[r], 32'h0);
    end
    $display("Test registers done");
    // Unmapped address is refused
    apb(1'b1, 12'h030, 32'hFFFFFFFF);
    chk("unmapped write error", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped read", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h002, 32'hFFFFFFFF);
    chk("misaligned write error", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("misaligned write dropped", rd, 32'h0);
    $display("Test unmapped done");
    // Each field steers its own distinct pin to its peripheral
    for (int f = 0; f < 18; f++) begin
      k = (11 * f + 63) % 64;
      apb(1'b1, offs[freg[f]], (k + PIN_BASE) << flsb[f]);
      pin_wait(64'h1 << k);
      chk("route", {14'h0, seen}, 32'h1 << f);
      pin_wait(~(64'h1 << k));
      chk("route low", {31'h0, seen[f]}, 32'h0);
    end
    $display("Test routing done");
    // Selector zero and a value past the last pin give a low input
    apb(1'b1, 12'h000, 32'h00000000);
    pin_wait(64'hFFFFFFFFFFFFFFFF);
    chk("selector zero", {31'h0, outs[0]}, 32'h0);
    apb(1'b1, 12'h000, 32'h000000FF);
    pin_wait(64'hFFFFFFFFFFFFFFFF);
    chk("selector beyond", {31'h0, outs[0]}, 32'h0);
    $display("Test selector bounds done");
    // Reset in mid-run clears fields and outputs
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("outputs in reset", {14'h0, outs}, 32'h0);
    @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 12'h02C, 32'h0);
    chk("field after reset", rd, 32'h0);
    $display("Test second reset done");
    stop_test();
  end
endmodule : input_pin_remap_test

`default_nettype wire
